//--- vfe_defs.vh
// Constants of the video front end, scaler and pixel format block.
// Included by every design file; holds definitions only.
`ifndef VFE_DEFS_VH
`define VFE_DEFS_VH

// Register placement and value
`define VFE_FMT_OFFSET 12'h008
`define VFE_FMT_RESET 32'h02000011
`define VFE_FMT_WMASK 32'h07ffff5f

// Field positions
`define VFE_EXT_FIELD_BIT 26
`define VFE_TOP_SENSE_BIT 25
`define VFE_PHASE_BIT 24
`define VFE_FILT_HI 23
`define VFE_FILT_LO 21
`define VFE_DUP_BIT 20
`define VFE_HDCM_HI 19
`define VFE_HDCM_LO 14
`define VFE_VDCM_HI 13
`define VFE_VDCM_LO 8
`define VFE_DISP_BIT 6
`define VFE_FMT_HI 4
`define VFE_FMT_LO 3
`define VFE_ERROR_DIFFUSION_ENABLE_BIT 2
`define VFE_PACK_BIT 1
`define VFE_ENDIAN_BIT 0

// Filter codes
`define VFE_FILT_CHROMA3 3'h0
`define VFE_FILT_TAP3 3'h1
`define VFE_FILT_TAP4 3'h2
`define VFE_FILT_TAP5 3'h3
`define VFE_FILT_TAP4B 3'h4

// Output pixel formats
`define VFE_PF_YUV422 2'h0
`define VFE_PF_RGB888 2'h1
`define VFE_PF_RGB565 2'h2
`define VFE_PF_RGB555 2'h3

// Decimation run length and bottom-field phase offset
`define VFE_DCM_RUN 7'h40
`define VFE_DCM_HALF 7'h20

`endif

//--- vfe_decim.v
// Even-spread drop decision for one decimation axis (pixels or lines).
// Assumes step and restart are one-cycle pulses on the same clock.
`timescale 1ns/1ps
`include "vfe_defs.vh"

module vfe_decim (
    // Clock and reset
    input wire mclk,
    input wire srst,
    // Control
    input wire restart,
    input wire [6:0] start_phase,
    input wire step,
    input wire [5:0] drop_count,
    // Decision for the current element
    output wire keep
);
    reg [6:0] acc_q;
    wire [6:0] sum;

    // Accumulate drops; drop when the running sum wraps past a run
    assign sum = acc_q + {1'b0, drop_count};
    assign keep = (sum < `VFE_DCM_RUN);

    // Accumulator update; zero count never wraps
    always @(posedge mclk) begin
        if (srst) begin
            acc_q <= 7'h00;
        end else if (restart) begin
            acc_q <= start_phase;
        end else if (step) begin
            acc_q <= keep ? sum : (sum - `VFE_DCM_RUN);
        end
    end
endmodule

//--- vfe_top.v
// Video front end, scaler and pixel formatter with its control register.
// Assumes video pins arrive asynchronously; mclk oversamples the video clocks.
//
// Behaviour
// - External field select picks field pin, else parity from syncs.
// - Field pin level meaning top follows the top-field sense bit.
// - Derived parity samples hsync at vsync edge, sense bit picks level.
// - Phase 0: sample on double clock rise with base low, drive on fall high.
// - Phase 1: sample on double clock rise with base high, drive on fall low.
// - Filter select codes 0 to 4 choose the five horizontal filters.
// - Filter codes 5 to 7 act as the default chroma-only filter.
// - Duplicate field flag decides whether both fields share vertical decimation.
// - Drop that many pixels per 64; zero disables.
// - Drop that many lines per 64; zero disables.
// - Display mode 1 shows single field, 0 emulated interlace.
// - Format code picks YUV 4:2:2, RGB 888, RGB 565 or RGB 555.
// - Error diffusion on 565/555 when enabled, else plain truncation.
// - Packed truecolor puts four pixels in three words, else one per word.
// - Byte order bit 1 gives little endian, 0 big endian.
// - Register accepts any combination of byte enables.
`timescale 1ns/1ps
`include "vfe_defs.vh"

module vfe_top (
    // Clock and reset
    input wire mclk,
    input wire srst,
    // Register port
    input wire [11:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [3:0] reg_be,
    input wire [31:0] reg_wdata,
    output reg [31:0] reg_rdata_q,
    output reg reg_rvalid_q,
    // Video pins from the digitizer
    input wire double_rate_video_clock,
    input wire base_video_clock,
    input wire hsync,
    input wire vsync,
    input wire field_parity_input,
    input wire [7:0] pix_luma,
    input wire [7:0] pix_chroma,
    // Video pins to the digitizer
    output reg pixel_enable_output_n_q,
    output reg field_top_out_q,
    // Formatted pixel words and current field parity
    output reg [31:0] out_data_q,
    output reg out_valid_q,
    output reg field_top_q
);
    reg [31:0] cfg_q;
    reg [31:0] cfg_d;
    integer i;

    // Register write with per-lane enables, reserved bits held zero
    always @* begin
        cfg_d = cfg_q;
        for (i = 0; i < 4; i = i + 1) begin
            if (reg_be[i]) begin
                cfg_d[i*8 +: 8] = reg_wdata[i*8 +: 8];
            end
        end
        cfg_d = cfg_d & `VFE_FMT_WMASK;
    end

    // Register storage and read answer
    always @(posedge mclk) begin
        if (srst) begin
            cfg_q <= `VFE_FMT_RESET;
            reg_rdata_q <= 32'h00000000;
            reg_rvalid_q <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == `VFE_FMT_OFFSET) begin
                cfg_q <= cfg_d;
            end
            reg_rvalid_q <= reg_rd;
            reg_rdata_q <= (reg_rd && reg_addr == `VFE_FMT_OFFSET) ? cfg_q : 32'h00000000;
        end
    end

    wire ext_field = cfg_q[`VFE_EXT_FIELD_BIT];
    wire top_sense = cfg_q[`VFE_TOP_SENSE_BIT];
    wire phase_sel = cfg_q[`VFE_PHASE_BIT];
    wire [2:0] filt = cfg_q[`VFE_FILT_HI:`VFE_FILT_LO];
    wire dup_field = cfg_q[`VFE_DUP_BIT];
    wire [5:0] hdcm = cfg_q[`VFE_HDCM_HI:`VFE_HDCM_LO];
    wire [5:0] vdcm = cfg_q[`VFE_VDCM_HI:`VFE_VDCM_LO];
    wire disp_single = cfg_q[`VFE_DISP_BIT];
    wire [1:0] pfmt = cfg_q[`VFE_FMT_HI:`VFE_FMT_LO];
    wire err_en = cfg_q[`VFE_ERROR_DIFFUSION_ENABLE_BIT];
    wire packed_truecolor_enable = cfg_q[`VFE_PACK_BIT];
    wire little = cfg_q[`VFE_ENDIAN_BIT];

    // Two-stage synchronisers for all video pins
    reg [20:0] sync1_q;
    reg [20:0] sync2_q;
    reg [4:0] prev_q;
    always @(posedge mclk) begin
        if (srst) begin
            sync1_q <= 21'h000000;
            sync2_q <= 21'h000000;
            prev_q <= 5'h00;
        end else begin
            sync1_q <= {double_rate_video_clock, base_video_clock, hsync, vsync,
                field_parity_input, pix_luma, pix_chroma};
            sync2_q <= sync1_q;
            prev_q <= sync2_q[20:16];
        end
    end
    wire x2_s = sync2_q[20];
    wire base_s = sync2_q[19];
    wire hs_s = sync2_q[18];
    wire vs_s = sync2_q[17];
    wire fi_s = sync2_q[16];
    wire [7:0] y_s = sync2_q[15:8];
    wire [7:0] c_s = sync2_q[7:0];

    // Edges of the video clocks and syncs
    wire x2_rise = x2_s & ~prev_q[4];
    wire x2_fall = ~x2_s & prev_q[4];
    wire sample_ev = x2_rise & (base_s == phase_sel);
    wire drive_ev = x2_fall & (base_s != phase_sel);
    wire line_start = hs_s & ~prev_q[2];
    wire frame_start = vs_s & ~prev_q[1];
    wire active = ~hs_s & ~vs_s;

    // Field parity from the pin or from hsync at the vsync edge
    wire new_top = ext_field ? (fi_s == top_sense) : (hs_s == top_sense);
    wire cur_top = ext_field ? (fi_s == top_sense) : field_top_q;

    always @(posedge mclk) begin
        if (srst) begin
            field_top_q <= 1'b1;
            field_top_out_q <= 1'b0;
        end else begin
            if (frame_start || ext_field) begin
                field_top_q <= new_top;
            end
            if (drive_ev) begin
                field_top_out_q <= cur_top;
            end
        end
    end

    // Line and pixel decimation
    wire h_keep;
    wire v_keep;
    wire [6:0] v_phase = (!dup_field && !new_top) ? `VFE_DCM_HALF : 7'h00;
    vfe_decim u_hdcm (
        .mclk(mclk),
        .srst(srst),
        .restart(line_start),
        .start_phase(7'h00),
        .step(sample_ev & active),
        .drop_count(hdcm),
        .keep(h_keep)
    );
    vfe_decim u_vdcm (
        .mclk(mclk),
        .srst(srst),
        .restart(frame_start),
        .start_phase(v_phase),
        .step(line_start),
        .drop_count(vdcm),
        .keep(v_keep)
    );
    reg line_keep_q;
    always @(posedge mclk) begin
        if (srst) begin
            line_keep_q <= 1'b0;
        end else if (line_start) begin
            line_keep_q <= v_keep & (~disp_single | cur_top);
        end
    end

    // Sample histories for the horizontal filter; the current sample is tap 0
    reg [7:0] yh_q [0:3];
    reg [7:0] ch_q [0:5];
    reg uv_odd_q;
    integer j;
    always @(posedge mclk) begin
        if (srst || line_start) begin
            for (j = 0; j < 6; j = j + 1) begin
                ch_q[j] <= 8'h80;
                if (j < 4) yh_q[j] <= 8'h00;
            end
            uv_odd_q <= 1'b0;
        end else if (sample_ev && active) begin
            yh_q[0] <= y_s;
            ch_q[0] <= c_s;
            for (j = 1; j < 6; j = j + 1) begin
                ch_q[j] <= ch_q[j-1];
                if (j < 4) yh_q[j] <= yh_q[j-1];
            end
            uv_odd_q <= ~uv_odd_q;
        end
    end

    // Luma and chroma tap sums
    reg [11:0] ysum;
    reg [11:0] csum;
    reg [7:0] yf;
    reg [7:0] cf;
    always @* begin
        ysum = 12'h000;
        csum = 12'h000;
        yf = y_s;
        case (filt)
            `VFE_FILT_TAP3: begin
                ysum = {4'h0, y_s} + {3'h0, yh_q[0], 1'b0} + {4'h0, yh_q[1]};
                yf = ysum[9:2];
            end
            `VFE_FILT_TAP4: begin
                ysum = {4'h0, y_s} + 12'h003 * {4'h0, yh_q[0]} + 12'h003 * {4'h0, yh_q[1]} + {4'h0, yh_q[2]};
                yf = ysum[10:3];
            end
            `VFE_FILT_TAP5: begin
                ysum = {4'h0, y_s} + {2'h0, yh_q[0], 2'h0} + 12'h006 * {4'h0, yh_q[1]}
                    + {2'h0, yh_q[2], 2'h0} + {4'h0, yh_q[3]};
                yf = ysum[11:4];
            end
            `VFE_FILT_TAP4B: begin
                ysum = {4'h0, y_s} + {4'h0, yh_q[0]} + {4'h0, yh_q[1]} + {4'h0, yh_q[2]};
                yf = ysum[9:2];
            end
            default: begin
                yf = y_s;
            end
        endcase
        if (filt == `VFE_FILT_TAP4 || filt == `VFE_FILT_TAP5 || filt == `VFE_FILT_TAP4B) begin
            csum = {4'h0, c_s} + 12'h003 * {4'h0, ch_q[1]} + 12'h003 * {4'h0, ch_q[3]} + {4'h0, ch_q[5]};
            cf = csum[10:3];
        end else begin
            csum = {4'h0, c_s} + {3'h0, ch_q[1], 1'b0} + {4'h0, ch_q[3]};
            cf = csum[9:2];
        end
    end

    // Stage one: filtered sample with its keep decision
    reg [7:0] y1_q;
    reg [7:0] u1_q;
    reg [7:0] v1_q;
    reg [7:0] c1_q;
    reg s1_q;
    always @(posedge mclk) begin
        if (srst) begin
            y1_q <= 8'h00;
            u1_q <= 8'h80;
            v1_q <= 8'h80;
            c1_q <= 8'h80;
            s1_q <= 1'b0;
            pixel_enable_output_n_q <= 1'b1;
        end else begin
            s1_q <= sample_ev & active & h_keep & line_keep_q;
            pixel_enable_output_n_q <= ~(sample_ev & active & h_keep & line_keep_q);
            if (sample_ev && active) begin
                y1_q <= yf;
                c1_q <= cf;
                if (uv_odd_q) v1_q <= cf;
                else u1_q <= cf;
            end
        end
    end

    // Colour conversion with clamping
    reg signed [11:0] uu;
    reg signed [11:0] vv;
    reg signed [11:0] rr;
    reg signed [11:0] gg;
    reg signed [11:0] bb;
    reg [7:0] r8;
    reg [7:0] g8;
    reg [7:0] b8;
    always @* begin
        uu = $signed({4'h0, u1_q}) - 12'sh080;
        vv = $signed({4'h0, v1_q}) - 12'sh080;
        rr = $signed({4'h0, y1_q}) + vv + (vv >>> 2) + (vv >>> 3);
        gg = $signed({4'h0, y1_q}) - (uu >>> 2) - (uu >>> 4) - (vv >>> 1) - (vv >>> 3) - (vv >>> 4);
        bb = $signed({4'h0, y1_q}) + uu + (uu >>> 1) + (uu >>> 3) + (uu >>> 4);
        r8 = rr[11] ? 8'h00 : (rr > 12'sh0ff ? 8'hff : rr[7:0]);
        g8 = gg[11] ? 8'h00 : (gg > 12'sh0ff ? 8'hff : gg[7:0]);
        b8 = bb[11] ? 8'h00 : (bb > 12'sh0ff ? 8'hff : bb[7:0]);
    end

    // Saturating add of the carried truncation error
    function [7:0] sat_add;
        input [7:0] v;
        input [2:0] e;
        reg [8:0] s;
        begin
            s = {1'b0, v} + {6'h00, e};
            sat_add = s[8] ? 8'hff : s[7:0];
        end
    endfunction

    reg [2:0] er_q;
    reg [2:0] eg_q;
    reg [2:0] eb_q;
    wire [7:0] rd = sat_add(r8, err_en ? er_q : 3'h0);
    wire [7:0] gd = sat_add(g8, err_en ? eg_q : 3'h0);
    wire [7:0] bd = sat_add(b8, err_en ? eb_q : 3'h0);
    wire g_six = (pfmt == `VFE_PF_RGB565);

    // Pixel bytes and their count per format
    reg [31:0] pix;
    reg [2:0] pix_n;
    always @* begin
        case (pfmt)
            `VFE_PF_YUV422: begin
                pix = {16'h0000, c1_q, y1_q};
                pix_n = 3'h2;
            end
            `VFE_PF_RGB888: begin
                pix = {8'h00, r8, g8, b8};
                pix_n = packed_truecolor_enable ? 3'h3 : 3'h4;
            end
            `VFE_PF_RGB565: begin
                pix = {16'h0000, rd[7:3], gd[7:2], bd[7:3]};
                pix_n = 3'h2;
            end
            default: begin
                pix = {16'h0000, 1'b0, rd[7:3], gd[7:3], bd[7:3]};
                pix_n = 3'h2;
            end
        endcase
    end

    // Byte packing into words
    reg [55:0] acc_q;
    reg [2:0] cnt_q;
    wire [55:0] merged = acc_q | ({24'h000000, pix} << {cnt_q, 3'b000});
    wire [2:0] total = cnt_q + pix_n;
    wire [31:0] word = merged[31:0];
    always @(posedge mclk) begin
        if (srst || frame_start) begin
            acc_q <= 56'h0;
            cnt_q <= 3'h0;
            out_data_q <= 32'h00000000;
            out_valid_q <= 1'b0;
        end else begin
            out_valid_q <= 1'b0;
            if (s1_q) begin
                if (total >= 3'h4) begin
                    acc_q <= {32'h00000000, merged[55:32]};
                    cnt_q <= total - 3'h4;
                    out_valid_q <= 1'b1;
                    out_data_q <= little ? word : {word[7:0], word[15:8], word[23:16], word[31:24]};
                end else begin
                    acc_q <= merged;
                    cnt_q <= total;
                end
            end
        end
    end

    // Carried error per channel, restarted each line
    always @(posedge mclk) begin
        if (srst || line_start) begin
            er_q <= 3'h0;
            eg_q <= 3'h0;
            eb_q <= 3'h0;
        end else if (s1_q) begin
            er_q <= rd[2:0];
            eg_q <= g_six ? {1'b0, gd[1:0]} : gd[2:0];
            eb_q <= bd[2:0];
        end
    end
endmodule

//--- vfe_top_sva.sv
// Checker of vfe_top: register answers and video pin timing.
// Assumes a bind to vfe_top; sees only its ports.
`timescale 1ns/1ps
module vfe_top_sva (
    // Clock and reset
    input wire mclk,
    input wire srst,
    // Register port
    input wire [11:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [3:0] reg_be,
    input wire [31:0] reg_wdata,
    input wire [31:0] reg_rdata_q,
    input wire reg_rvalid_q,
    // Video pins and field parity
    input wire double_rate_video_clock,
    input wire base_video_clock,
    input wire hsync,
    input wire vsync,
    input wire field_parity_input,
    input wire pixel_enable_output_n_q,
    input wire field_top_out_q,
    input wire field_top_q
);
    logic [31:0] cfg_q;
    logic [31:0] bmask;
    // Byte lanes hit by a write
    assign bmask = {{8{reg_be[3]}}, {8{reg_be[2]}}, {8{reg_be[1]}}, {8{reg_be[0]}}};
    // Shadow of the format register
    always @(posedge mclk) begin
        if (srst) begin
            cfg_q <= 32'h02000011;
        end else if (reg_wr && reg_addr == 12'h008) begin
            cfg_q <= (cfg_q & ~bmask) | (reg_wdata & bmask & 32'h07ffff5f);
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // Read taken at the format register
    sequence s_rd_fmt;
        reg_rd && reg_addr == 12'h008;
    endsequence
    AST_RD_VALUE: assert property (s_rd_fmt |=> reg_rvalid_q && reg_rdata_q == $past(cfg_q))
        else $error("format read differs from shadow");
    AST_RD_UNMAPPED: assert property (reg_rd && reg_addr != 12'h008 |=> reg_rvalid_q && reg_rdata_q == 32'h0)
        else $error("unmapped read not zero");
    AST_RD_RESERVED: assert property (reg_rvalid_q |-> (reg_rdata_q & 32'hf80000a0) == 32'h0)
        else $error("reserved bits read nonzero");
    AST_PIXEL_ENABLE_OUTPUT_PULSE: assert property (!pixel_enable_output_n_q |=> pixel_enable_output_n_q)
        else $error("pixel enable low too long");
    AST_PIXEL_ENABLE_OUTPUT_PHASE: assert property (!pixel_enable_output_n_q |->
        $past(double_rate_video_clock, 2) && !$past(double_rate_video_clock, 8)
        && $past(base_video_clock, 2) == cfg_q[24])
        else $error("pixel taken on wrong clock edge");
    AST_FIELD_OUT: assert property ($changed(field_top_out_q) |->
        !$past(double_rate_video_clock, 2) && $past(double_rate_video_clock, 8)
        && $past(base_video_clock, 2) != cfg_q[24])
        else $error("field output moved off its drive edge");
    AST_FIELD_PIN: assert property (cfg_q[26] && $past(field_parity_input, 8) == field_parity_input
        && $past(cfg_q, 8) == cfg_q |-> field_top_q == (field_parity_input == cfg_q[25]))
        else $error("field parity does not follow pin");
    AST_FIELD_SYNC: assert property (!cfg_q[26] && $rose(vsync) && $stable(hsync) |->
        ##8 field_top_q == ($past(hsync, 8) == cfg_q[25]))
        else $error("derived field parity wrong");
endmodule

//--- vfe_digitizer.sv
// Digitizer model: two-phase video clock, syncs, field pin and pixels.
// Assumes one task at a time; video clocks stand still between calls.
`timescale 1ns/1ps
module vfe_digitizer (
    // Video clocks
    output logic double_rate_video_clock,
    output logic base_video_clock,
    // Syncs and field indicator
    output logic hsync,
    output logic vsync,
    output logic field_parity_input,
    // Pixel data
    output logic [7:0] pix_luma,
    output logic [7:0] pix_chroma
);
    // Idle pins at time zero
    initial begin
        {double_rate_video_clock, base_video_clock, hsync, vsync, field_parity_input} = 5'h00;
        pix_luma = 8'h00;
        pix_chroma = 8'h00;
    end
    // Sync pulse, then n pixels with luma counting up from first
    task automatic line(input int n, input logic [7:0] first);
        #1.3;
        hsync = 1'b1;
        #100 hsync = 1'b0;
        #100;
        for (int i = 0; i < n; i++) begin
            pix_luma = first + i[7:0];
            pix_chroma = 8'h80;
            // Double clock rises 20 ns into each base half, falls 20 ns before its end
            for (int s = 0; s < 8; s++) begin
                base_video_clock = s[2];
                double_rate_video_clock = s[1] ^ s[0];
                #20;
            end
        end
        {double_rate_video_clock, base_video_clock} = 2'h0;
        // Released data no longer shows the last pixel
        pix_luma = ~pix_luma;
        pix_chroma = ~pix_chroma;
    endtask
    // Field start: field pin and hsync level, then a vsync pulse
    task automatic field(input logic fi, input logic hs);
        #1.3;
        field_parity_input = fi;
        hsync = hs;
        #100 vsync = 1'b1;
        #200 vsync = 1'b0;
        hsync = 1'b0;
        #100;
    endtask
endmodule

//--- vfe_top_bench.sv
// Self-checking bench of vfe_top with the digitizer model on its video pins.
// Assumes vfe_top_sva and vfe_digitizer are compiled first.
`timescale 1ns/1ps
module vfe_top_bench;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] reg_be = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    wire [31:0] reg_rdata_q;
    wire [31:0] out_data_q;
    wire [7:0] pix_luma;
    wire [7:0] pix_chroma;
    wire reg_rvalid_q, double_rate_video_clock, base_video_clock, hsync, vsync, field_parity_input;
    wire pixel_enable_output_n_q, field_top_out_q, out_valid_q, field_top_q;
    int miscompares = 0;
    int cmp_count = 0;
    int pe_cnt = 0;
    int wv_cnt = 0;
    int nw [5] = '{8, 6, 4, 4, 4};
    int hds [4] = '{0, 1, 32, 63};
    logic [1:0] fmts [5] = '{2'h1, 2'h1, 2'h2, 2'h3, 2'h0};
    logic [31:0] zmask [5] = '{32'hff000000, 32'h0, 32'h0, 32'h80008000, 32'h0};
    logic [31:0] words [16];
    logic [31:0] exp;
    // Clock
    always #2 mclk = ~mclk;
    vfe_digitizer dig (.double_rate_video_clock, .base_video_clock, .hsync, .vsync, .field_parity_input,
        .pix_luma, .pix_chroma);
    vfe_top uut (.mclk, .srst, .reg_addr, .reg_wr, .reg_rd, .reg_be, .reg_wdata, .reg_rdata_q, .reg_rvalid_q,
        .double_rate_video_clock, .base_video_clock, .hsync, .vsync, .field_parity_input, .pix_luma,
        .pix_chroma, .pixel_enable_output_n_q, .field_top_out_q, .out_data_q, .out_valid_q, .field_top_q);
    // Counts kept pixels and collects output words
    always @(posedge mclk) begin
        if (pixel_enable_output_n_q === 1'b0) pe_cnt++;
        if (out_valid_q === 1'b1) begin
            if (wv_cnt < 16) words[wv_cnt] = out_data_q;
            wv_cnt++;
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] want);
        cmp_count++;
        if (got !== want) begin
            miscompares++;
            $display("[ERR] %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_be <= be;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] want);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        check({31'h0, reg_rvalid_q}, 32'h1);
        check(reg_rdata_q, want);
    endtask
    // One line of n pixels, counters optionally cleared first
    task automatic run(input int n, input bit clr);
        if (clr) begin
            pe_cnt = 0;
            wv_cnt = 0;
        end
        @(posedge mclk);
        dig.line(n, 8'h10);
        repeat (20) @(posedge mclk);
        #1;
    endtask
    function automatic logic [31:0] cfg(input logic ext, input logic sen, input logic ph, input logic [5:0] hd,
        input logic [5:0] vd, input logic disp, input logic [1:0] fmt, input logic pack, input logic le);
        return {5'h0, ext, sen, ph, 4'h0, hd, vd, 1'b0, disp, 1'b0, fmt, 1'b0, pack, le};
    endfunction
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Main sequence; configuration only changes while video is stopped
    initial begin
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        rd(12'h008, 32'h02000011);
        wr(12'h008, 4'hf, 32'hffffffff);
        exp = 32'h07ffff5f;
        rd(12'h008, exp);
        for (int i = 0; i < 4; i++) begin
            wr(12'h008, 4'h1 << i, 32'h0);
            exp[8*i +: 8] = 8'h00;
            rd(12'h008, exp);
        end
        wr(12'h000, 4'hf, 32'hffffffff);
        rd(12'h000, 32'h0);
        rd(12'h008, 32'h0);
        $display("test registers done");
        // Parity source and sense; the unused source always disagrees
        for (int k = 0; k < 8; k++) begin
            wr(12'h008, 4'hf, cfg(k[2], k[1], 1'b0, 6'h0, 6'h0, 1'b0, 2'h0, 1'b0, 1'b1));
            dig.field(k[2] ~^ k[0] ~^ k[1], k[2] ^ k[0] ~^ k[1]);
            repeat (10) @(posedge mclk);
            #1;
            check({31'h0, field_top_q}, {31'h0, k[0]});
        end
        $display("test field parity done");
        wr(12'h008, 4'hf, cfg(1'b1, 1'b1, 1'b0, 6'h0, 6'h0, 1'b1, 2'h0, 1'b0, 1'b1));
        dig.field(1'b0, 1'b0);
        run(4, 1'b1);
        check(pe_cnt, 0);
        check({31'h0, field_top_out_q}, 32'h0);
        dig.field(1'b1, 1'b0);
        run(4, 1'b1);
        check(pe_cnt, 4);
        check({31'h0, field_top_out_q}, 32'h1);
        $display("test single field done");
        for (int k = 0; k < 4; k++) begin
            wr(12'h008, 4'hf, cfg(1'b1, 1'b1, k[1], 6'h0, 6'h0, 1'b0, 2'h0, 1'b0, k[0]));
            run(4, 1'b1);
            check(wv_cnt, 2);
            exp = k[0] ? 32'h00110010 : 32'h10001100;
            check(words[0] & (k[0] ? 32'h00ff00ff : 32'hff00ff00), exp);
        end
        $display("test phase and byte order done");
        for (int k = 0; k < 5; k++) begin
            wr(12'h008, 4'hf, cfg(1'b1, 1'b1, 1'b0, 6'h0, 6'h0, 1'b0, fmts[k], k == 1, 1'b1));
            run(8, 1'b1);
            check(wv_cnt, nw[k]);
            check(words[0] & zmask[k], 32'h0);
        end
        $display("test formats done");
        wr(12'h008, 4'hf, cfg(1'b1, 1'b1, 1'b0, 6'h0, 6'h0, 1'b0, 2'h0, 1'b0, 1'b1) | 32'h00e00000);
        run(4, 1'b1);
        check(words[0] & 32'h00ff00ff, 32'h00110010);
        wr(12'h008, 4'hf, cfg(1'b1, 1'b1, 1'b0, 6'h0, 6'h0, 1'b0, 2'h0, 1'b0, 1'b1) | 32'h00200000);
        run(4, 1'b1);
        check(words[0] & 32'h00ff00ff, 32'h000c0004);
        wr(12'h008, 4'hf, cfg(1'b1, 1'b1, 1'b0, 6'h0, 6'h0, 1'b0, 2'h2, 1'b0, 1'b1) | 32'h00000004);
        run(8, 1'b1);
        check(words[2], 32'h10a218a3);
        $display("test filters and diffusion done");
        for (int k = 0; k < 4; k++) begin
            wr(12'h008, 4'hf, cfg(1'b1, 1'b1, 1'b0, hds[k][5:0], 6'h0, 1'b0, 2'h0, 1'b0, 1'b1));
            run(64, 1'b1);
            check(pe_cnt, 64 - hds[k]);
        end
        $display("test horizontal decimation done");
        wr(12'h008, 4'hf, cfg(1'b1, 1'b1, 1'b0, 6'h0, 6'h10, 1'b0, 2'h0, 1'b0, 1'b1));
        dig.field(1'b1, 1'b0);
        run(0, 1'b1);
        for (int l = 0; l < 64; l++) run(2, 1'b0);
        check(pe_cnt, 96);
        $display("test vertical decimation done");
        for (int k = 0; k < 2; k++) begin
            wr(12'h008, 4'hf, cfg(1'b1, 1'b1, 1'b0, 6'h0, 6'h20, 1'b0, 2'h0, 1'b0, 1'b1) | {11'h0, k[0], 20'h0});
            dig.field(1'b0, 1'b0);
            run(2, 1'b1);
            check(pe_cnt, 2 * k);
        end
        $display("test duplicate field done");
        end_of_test();
    end
    // Watchdog
    initial begin
        #200000;
        miscompares++;
        $display("[ERR] %0t watchdog expired", $time);
        end_of_test();
    end
endmodule
bind vfe_top vfe_top_sva chk (.mclk, .srst, .reg_addr, .reg_wr, .reg_rd, .reg_be, .reg_wdata, .reg_rdata_q,
    .reg_rvalid_q, .double_rate_video_clock, .base_video_clock, .hsync, .vsync, .field_parity_input,
    .pixel_enable_output_n_q, .field_top_out_q, .field_top_q);
